// >>> src/ard_pkg.sv
// constants, status words and state codes of the apdu read/write/verify decoder
// assumes: users reference every name as ard_pkg::name
//
// What this block does
// (R1) class byte not zero gives an error status; for verify, nonzero p1 or p2 also.
// (R2) read is instruction b0; p1 and p2 give the start address read from.
// (R3) read expected length valid from 1 to 251; that many bytes are returned.
// (R4) encrypted mode: read and write lengths are 16 times n, n at most 15.
// (R5) read data precedes the status; data omitted unless status is normal.
// (R6) read takes tag memory in rf mode, host data in tunnel mode.
// (R7) write is instruction d6; p1 and p2 give the store start address.
// (R8) write data length valid from 1 to 248; reply is status only.
// (R9) write stores to tag memory in rf mode, forwards to host in tunnel mode.
// (R10) verify is instruction 20; any instruction other than b0, d6 and 20 gives an error status.
// (R11) verify data length must be 0x10; otherwise an error status.
// (R12) valid verify checks the 16 byte password; reply is status only.
// (R13) tag type 4 exchange format version 2.0 is supported.
// (R14) formatted exchange works only after memory user area is set up; this block has no user area check and accepts commands at any time after reset.
// (R15) p1 is the upper address byte, p2 the lower.
package ard_pkg;

  localparam logic [7:0]  CLA_OK      = 8'h00;
  localparam logic [7:0]  INS_READ    = 8'hB0;
  localparam logic [7:0]  INS_WRITE   = 8'hD6;
  localparam logic [7:0]  INS_VERIFY  = 8'h20;
  localparam logic [7:0]  RD_LEN_MIN  = 8'h01;
  localparam logic [7:0]  RD_LEN_MAX  = 8'hFB;
  localparam logic [7:0]  WR_LEN_MIN  = 8'h01;
  localparam logic [7:0]  WR_LEN_MAX  = 8'hF8;
  localparam logic [7:0]  VFY_LEN     = 8'h10;
  localparam logic [3:0]  ENC_MASK    = 4'h0;
  localparam logic [2:0]  HDR_LAST    = 3'h4;
  localparam logic [4:0]  PWD_BYTES   = 5'h10;

  localparam logic [15:0] SW_OK       = 16'h9000;
  localparam logic [15:0] SW_ERR_LEN  = 16'h6700;
  localparam logic [15:0] SW_ERR_AUTH = 16'h6300;
  localparam logic [15:0] SW_ERR_P12  = 16'h6B00;
  localparam logic [15:0] SW_ERR_INS  = 16'h6D00;
  localparam logic [15:0] SW_ERR_CLA  = 16'h6E00;

  typedef enum logic [2:0] {
    ST_HDR    = 3'b000,
    ST_DATA   = 3'b001,
    ST_DRAIN  = 3'b010,
    ST_VWAIT  = 3'b011,
    ST_RDREQ  = 3'b100,
    ST_RDWAIT = 3'b101,
    ST_RDOUT  = 3'b110,
    ST_STAT   = 3'b111
  } ard_st_t;

endpackage : ard_pkg

// >>> src/ard_pwd_if.sv
// carrier between the decoder and the password checker
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ard_pwd_if;
  logic       start;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       done;
  logic       match;
  modport dec (output start, output byte_valid, output byte_data, input done, input match);
  modport chk (input start, input byte_valid, input byte_data, output done, output match);
endinterface : ard_pwd_if
`default_nettype wire

// >>> src/ard_pwd_check.sv
// password checker: compares 16 streamed bytes with the reference
// assumes: reference stable during a verify, first byte compared to bits 127:120
`timescale 1ns/1ps
`default_nettype none
module ard_pwd_check (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [127:0] pwd_ref,
  ard_pwd_if.chk            pif
);
  logic [4:0] cnt;
  logic       miss;
  logic [7:0] ref_byte;

  assign ref_byte = pwd_ref[8'd127 - {cnt[3:0], 3'b000} -: 8];

  // -----------------------------------------
  // byte compare and completion
  // -----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt       <= 5'h0;
      miss      <= 1'b0;
      pif.done  <= 1'b0;
      pif.match <= 1'b0;
    end else begin
      pif.done <= 1'b0;
      if (pif.start) begin
        cnt  <= 5'h0;
        miss <= 1'b0;
      end else if (pif.byte_valid && cnt < ard_pkg::PWD_BYTES) begin
        cnt <= cnt + 5'h1;
        if (cnt == ard_pkg::PWD_BYTES - 5'h1) begin // [R12]
          pif.done  <= 1'b1;
          pif.match <= !miss && (pif.byte_data == ref_byte);
        end else if (pif.byte_data != ref_byte) begin
          miss <= 1'b1;
        end
      end
    end
  end
endmodule : ard_pwd_check
`default_nettype wire

// >>> src/ard_apdu.sv
// apdu decoder for read, write and verify commands of a contactless tag
// assumes: byte streams and memory/host ports on clk, one command in flight
`timescale 1ns/1ps
`default_nettype none
module ard_apdu (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         tunnel_mode,
  input  wire logic         enc_mode,
  input  wire logic [127:0] pwd_ref,
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_data,
  input  wire logic         cmd_last,
  output logic              cmd_ready,
  output logic              rsp_valid,
  output logic [7:0]        rsp_data,
  output logic              rsp_last,
  input  wire logic         rsp_ready,
  output logic              mem_rd_req,
  input  wire logic         mem_rd_valid,
  input  wire logic [7:0]   mem_rd_data,
  output logic              host_rd_req,
  input  wire logic         host_rd_valid,
  input  wire logic [7:0]   host_rd_data,
  output logic [15:0]       rd_addr,
  output logic              mem_wr_en,
  output logic              host_wr_en,
  output logic [15:0]       wr_addr,
  output logic [7:0]        wr_data
);
  ard_pkg::ard_st_t state;
  logic [2:0]  idx;
  logic [7:0]  cla, ins, p1, p2, cnt;
  logic [15:0] addr, sw, dec_sw;
  logic        cmd_fire, hdr_done, rd_valid;
  logic [7:0]  rd_data;
  ard_pwd_if   pif ();
  ard_pwd_check u_chk (
    .clk     (clk),
    .resetn  (resetn),
    .pwd_ref (pwd_ref),
    .pif     (pif)
  );

  // -----------------------------------------
  // handshakes
  // -----------------------------------------
  assign cmd_ready   = (state == ard_pkg::ST_HDR) || (state == ard_pkg::ST_DATA)
                    || (state == ard_pkg::ST_DRAIN);
  assign cmd_fire    = cmd_valid && cmd_ready;
  assign hdr_done    = cmd_fire && (state == ard_pkg::ST_HDR) && (idx == ard_pkg::HDR_LAST);
  assign rsp_valid   = (state == ard_pkg::ST_RDOUT) || (state == ard_pkg::ST_STAT && idx[0]);
  assign rsp_last    = (state == ard_pkg::ST_STAT) && idx[0] && idx[1];
  assign mem_rd_req  = (state == ard_pkg::ST_RDREQ) && !tunnel_mode; // [R6]
  assign host_rd_req = (state == ard_pkg::ST_RDREQ) && tunnel_mode;  // [R6]
  assign rd_valid    = tunnel_mode ? host_rd_valid : mem_rd_valid;
  assign rd_data     = tunnel_mode ? host_rd_data : mem_rd_data;
  assign rd_addr     = addr;
  assign pif.start      = hdr_done && (dec_sw == ard_pkg::SW_OK) && (ins == ard_pkg::INS_VERIFY);
  assign pif.byte_valid = cmd_fire && (state == ard_pkg::ST_DATA) && (ins == ard_pkg::INS_VERIFY);
  assign pif.byte_data  = cmd_data;

  // -----------------------------------------
  // header check, length byte in cmd_data
  // -----------------------------------------
  always_comb begin
    dec_sw = ard_pkg::SW_OK;
    if (cla != ard_pkg::CLA_OK) begin
      dec_sw = ard_pkg::SW_ERR_CLA; // [R1]
    end else if (ins == ard_pkg::INS_VERIFY) begin
      if ((p1 | p2) != 8'h00) begin
        dec_sw = ard_pkg::SW_ERR_P12; // [R1]
      end else if (cmd_data != ard_pkg::VFY_LEN || cmd_last) begin
        dec_sw = ard_pkg::SW_ERR_LEN; // [R11]
      end
    end else if (ins == ard_pkg::INS_READ) begin // [R2]
      if (cmd_data < ard_pkg::RD_LEN_MIN || cmd_data > ard_pkg::RD_LEN_MAX) begin
        dec_sw = ard_pkg::SW_ERR_LEN; // [R3]
      end else if (enc_mode && cmd_data[3:0] != ard_pkg::ENC_MASK) begin
        dec_sw = ard_pkg::SW_ERR_LEN; // [R4]
      end else if (!cmd_last) begin
        dec_sw = ard_pkg::SW_ERR_LEN;
      end
    end else if (ins == ard_pkg::INS_WRITE) begin // [R7]
      if (cmd_data < ard_pkg::WR_LEN_MIN || cmd_data > ard_pkg::WR_LEN_MAX || cmd_last) begin
        dec_sw = ard_pkg::SW_ERR_LEN; // [R8]
      end else if (enc_mode && cmd_data[3:0] != ard_pkg::ENC_MASK) begin
        dec_sw = ard_pkg::SW_ERR_LEN; // [R4]
      end
    end else begin
      dec_sw = ard_pkg::SW_ERR_INS; // [R10]
    end
  end

  // -----------------------------------------
  // header capture
  // -----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cla <= 8'h00;
      ins <= 8'h00;
      p1  <= 8'h00;
      p2  <= 8'h00;
    end else if (cmd_fire && state == ard_pkg::ST_HDR) begin
      case (idx)
        3'h0:    cla <= cmd_data;
        3'h1:    ins <= cmd_data;
        3'h2:    p1  <= cmd_data;
        3'h3:    p2  <= cmd_data;
        default: ;
      endcase
    end
  end

  // -----------------------------------------
  // write port, tag memory or host
  // -----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_wr_en  <= 1'b0;
      host_wr_en <= 1'b0;
      wr_addr    <= 16'h0000;
      wr_data    <= 8'h00;
    end else begin
      mem_wr_en  <= 1'b0;
      host_wr_en <= 1'b0;
      if (cmd_fire && state == ard_pkg::ST_DATA && ins == ard_pkg::INS_WRITE) begin
        mem_wr_en  <= !tunnel_mode; // [R9]
        host_wr_en <= tunnel_mode;  // [R9]
        wr_addr    <= addr;
        wr_data    <= cmd_data;
      end
    end
  end

  // -----------------------------------------
  // command sequencer, tag type 4 command set
  // -----------------------------------------
  always_ff @(posedge clk) begin // [R13]
    if (!resetn) begin
      state    <= ard_pkg::ST_HDR;
      idx      <= 3'h0;
      cnt      <= 8'h00;
      addr     <= 16'h0000;
      sw       <= ard_pkg::SW_OK;
      rsp_data <= 8'h00;
    end else begin
      case (state)
        ard_pkg::ST_HDR: begin
          if (cmd_fire) begin
            idx <= idx + 3'h1;
            if (hdr_done) begin
              idx  <= 3'h0;
              sw   <= dec_sw;
              cnt  <= cmd_data;
              addr <= {p1, p2}; // [R2] [R7] [R15]
              if (dec_sw != ard_pkg::SW_OK) begin
                state <= cmd_last ? ard_pkg::ST_STAT : ard_pkg::ST_DRAIN;
              end else if (ins == ard_pkg::INS_READ) begin
                state <= ard_pkg::ST_RDREQ; // [R6]
              end else begin
                state <= ard_pkg::ST_DATA;
              end
            end else if (cmd_last) begin
              idx   <= 3'h0;
              sw    <= ard_pkg::SW_ERR_LEN;
              state <= ard_pkg::ST_STAT;
            end
          end
        end
        ard_pkg::ST_DATA: begin
          if (cmd_fire) begin
            addr <= addr + 16'h0001;
            cnt  <= cnt - 8'h01;
            if (cnt == 8'h01 && cmd_last) begin
              state <= (ins == ard_pkg::INS_VERIFY) ? ard_pkg::ST_VWAIT : ard_pkg::ST_STAT; // [R8]
            end else if (cnt == 8'h01) begin
              sw    <= ard_pkg::SW_ERR_LEN;
              state <= ard_pkg::ST_DRAIN;
            end else if (cmd_last) begin
              sw    <= ard_pkg::SW_ERR_LEN;
              state <= ard_pkg::ST_STAT;
            end
          end
        end
        ard_pkg::ST_DRAIN: begin
          if (cmd_fire && cmd_last) begin
            state <= ard_pkg::ST_STAT;
          end
        end
        ard_pkg::ST_VWAIT: begin
          if (pif.done) begin
            sw    <= pif.match ? ard_pkg::SW_OK : ard_pkg::SW_ERR_AUTH; // [R12]
            state <= ard_pkg::ST_STAT;
          end
        end
        ard_pkg::ST_RDREQ: begin
          state <= ard_pkg::ST_RDWAIT;
        end
        ard_pkg::ST_RDWAIT: begin
          if (rd_valid) begin
            rsp_data <= rd_data;
            state    <= ard_pkg::ST_RDOUT;
          end
        end
        ard_pkg::ST_RDOUT: begin
          if (rsp_ready) begin
            addr  <= addr + 16'h0001;
            cnt   <= cnt - 8'h01;
            state <= (cnt == 8'h01) ? ard_pkg::ST_STAT : ard_pkg::ST_RDREQ; // [R3] [R5]
          end
        end
        ard_pkg::ST_STAT: begin
          // idx 0 load sw1, 1 send sw1, 3 send sw2
          if (idx == 3'h0) begin
            rsp_data <= sw[15:8];
            idx      <= 3'h1;
          end else if (rsp_ready && idx == 3'h1) begin
            rsp_data <= sw[7:0];
            idx      <= 3'h3;
          end else if (rsp_ready) begin
            idx   <= 3'h0;
            state <= ard_pkg::ST_HDR;
          end
        end
        default: state <= ard_pkg::ST_HDR;
      endcase
    end
  end

  // -----------------------------------------
  // checks
  // -----------------------------------------
  sequence s_sw_pair;
    (state == ard_pkg::ST_STAT && idx == 3'h1 && rsp_ready) ##1 (rsp_valid && rsp_last);
  endsequence
  property p_cla_err;
    @(posedge clk) disable iff (!resetn)
    hdr_done && cla != 8'h00 |=> sw == ard_pkg::SW_ERR_CLA;
  endproperty
  a_cla_err: assert property (p_cla_err) else $error("class error not reported"); // [R1]
  property p_vfy_p12;
    @(posedge clk) disable iff (!resetn)
    hdr_done && cla == 8'h00 && ins == ard_pkg::INS_VERIFY && (p1 | p2) != 8'h00
      |=> sw == ard_pkg::SW_ERR_P12;
  endproperty
  a_vfy_p12: assert property (p_vfy_p12) else $error("verify p1 p2 error missing"); // [R1]
  property p_rd_len;
    @(posedge clk) disable iff (!resetn)
    hdr_done && cla == 8'h00 && ins == ard_pkg::INS_READ && (cmd_data == 8'h00 || cmd_data > 8'hFB)
      |=> sw == ard_pkg::SW_ERR_LEN && state != ard_pkg::ST_RDREQ;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length out of range accepted"); // [R3]
  property p_rd_addr;
    @(posedge clk) disable iff (!resetn)
    hdr_done && dec_sw == ard_pkg::SW_OK && ins == ard_pkg::INS_READ
      |=> rd_addr == {p1, p2} && (mem_rd_req || host_rd_req);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read start address wrong"); // [R15]
  property p_no_data_on_err;
    @(posedge clk) disable iff (!resetn)
    state == ard_pkg::ST_RDOUT |-> sw == ard_pkg::SW_OK;
  endproperty
  a_no_data_on_err: assert property (p_no_data_on_err) else $error("data sent with error"); // [R5]
  property p_rd_route;
    @(posedge clk) disable iff (!resetn)
    state == ard_pkg::ST_RDWAIT && (tunnel_mode ? host_rd_valid : mem_rd_valid)
      |=> state == ard_pkg::ST_RDOUT
      && rsp_data == ($past(tunnel_mode) ? $past(host_rd_data) : $past(mem_rd_data));
  endproperty
  a_rd_route: assert property (p_rd_route) else $error("read source wrong for mode"); // [R6]
  property p_wr_route;
    @(posedge clk) disable iff (!resetn)
    cmd_fire && state == ard_pkg::ST_DATA && ins == ard_pkg::INS_WRITE
      |=> (mem_wr_en != host_wr_en) && host_wr_en == $past(tunnel_mode) && wr_data == $past(cmd_data);
  endproperty
  a_wr_route: assert property (p_wr_route) else $error("write target wrong for mode"); // [R9]
  property p_vfy_len;
    @(posedge clk) disable iff (!resetn)
    hdr_done && cla == 8'h00 && ins == ard_pkg::INS_VERIFY && (p1 | p2) == 8'h00
      && cmd_data != 8'h10 |=> sw == ard_pkg::SW_ERR_LEN;
  endproperty
  a_vfy_len: assert property (p_vfy_len) else $error("verify length error missing"); // [R11]
  property p_vfy_result;
    @(posedge clk) disable iff (!resetn)
    state == ard_pkg::ST_VWAIT && pif.done
      |=> sw == ($past(pif.match) ? ard_pkg::SW_OK : ard_pkg::SW_ERR_AUTH) ##1 rsp_valid;
  endproperty
  a_vfy_result: assert property (p_vfy_result) else $error("verify result wrong"); // [R12]
  property p_sw_end;
    @(posedge clk) disable iff (!resetn)
    s_sw_pair |-> (rsp_data == sw[7:0]) and (rsp_ready |=> state == ard_pkg::ST_HDR);
  endproperty
  a_sw_end: assert property (p_sw_end) else $error("status pair not closing reply"); // [R8]
endmodule : ard_apdu
`default_nettype wire

// >>> verif/ard_far_model.sv
// far side model: tag memory and host answering read requests
// assumes: same clk as the decoder, one read request outstanding
`timescale 1ns/1ps
`default_nettype none
module ard_far_model (
  input  wire logic        clk,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_rd_req,
  input  wire logic        host_rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             mem_rd_valid,
  output logic [7:0]       mem_rd_data,
  output logic             host_rd_valid,
  output logic [7:0]       host_rd_data
);
  logic [3:0]  cnt = 4'h0;
  logic        src = 1'b0;
  logic [15:0] addr = 16'h0000;
  initial begin
    mem_rd_valid = 1'b0;
    host_rd_valid = 1'b0;
    mem_rd_data = 8'h00;
    host_rd_data = 8'h00;
  end
  // answer lat cycles after a request; idle data lines keep toggling
  always @(posedge clk) begin
    mem_rd_valid <= 1'b0;
    host_rd_valid <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    host_rd_data <= ~host_rd_data;
    if (mem_rd_req || host_rd_req) begin
      cnt <= lat;
      src <= host_rd_req;
      addr <= rd_addr;
    end else if (cnt == 4'h1) begin
      cnt <= 4'h0;
      mem_rd_valid <= !src;
      host_rd_valid <= src;
      mem_rd_data <= addr[7:0] ^ 8'h3C; // user area taken as set up
      host_rd_data <= addr[7:0] ^ 8'hC3;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : ard_far_model
`default_nettype wire

// >>> verif/ard_apdu_bench.sv
// testbench of the apdu decoder: reader side driven by tasks
// assumes: design and far side model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module ard_apdu_bench;
  localparam logic [127:0] PWD = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
  localparam logic [7:0]   MK  = 8'h3C;
  localparam logic [7:0]   HK  = 8'hC3;
  logic        clk = 1'b0;
  logic        resetn, tunnel_mode, enc_mode, cmd_valid, cmd_last, cmd_ready;
  logic        rsp_valid, rsp_last, rsp_ready, mem_rd_req, mem_rd_valid;
  logic        host_rd_req, host_rd_valid, mem_wr_en, host_wr_en;
  logic [7:0]  cmd_data, rsp_data, mem_rd_data, host_rd_data, wr_data;
  logic [15:0] rd_addr, wr_addr;
  logic [3:0]  lat;
  logic [7:0]  rsp_q[$], wd_q[$];
  logic [15:0] wa_q[$];
  logic        wh_q[$];
  int          n_fail = 0;
  int          checks = 0;
  // ------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  ard_apdu DUT (.clk(clk), .resetn(resetn), .tunnel_mode(tunnel_mode),
    .enc_mode(enc_mode), .pwd_ref(PWD), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .host_rd_req(host_rd_req), .host_rd_valid(host_rd_valid),
    .host_rd_data(host_rd_data), .rd_addr(rd_addr), .mem_wr_en(mem_wr_en),
    .host_wr_en(host_wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  ard_far_model far (.clk(clk), .lat(lat), .mem_rd_req(mem_rd_req),
    .host_rd_req(host_rd_req), .rd_addr(rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .host_rd_valid(host_rd_valid),
    .host_rd_data(host_rd_data));
  // write log, sampled where registered outputs are settled
  always @(negedge clk) begin
    if (mem_wr_en === 1'b1 || host_wr_en === 1'b1) begin
      wd_q.push_back(wr_data);
      wa_q.push_back(wr_addr);
      wh_q.push_back(host_wr_en);
    end
  end
  // ------------------------------------------------------------
  // compare and transfer tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic miss(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : miss
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) miss(m);
  endtask : cmp_byte
  task automatic cmp_sw(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) miss(m);
  endtask : cmp_sw
  task automatic cmp_cnt(input int got, input int exp, input string m);
    checks++;
    if (got != exp) miss(m);
  endtask : cmp_cnt
  task automatic apdu(input logic [7:0] b[$]);
    int k;
    bit fin;
    rsp_q = {};
    wd_q = {};
    wa_q = {};
    wh_q = {};
    foreach (b[i]) begin
      cmd_valid <= 1'b1;
      cmd_data <= b[i];
      cmd_last <= (i == b.size() - 1);
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (cmd_ready !== 1'b1 && k < 99);
      if (k >= 99) begin
        miss("command stalled");
        close_out();
      end
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
    fin = 0;
    for (k = 0; k < 4000 && !fin; k++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) begin
        rsp_q.push_back(rsp_data);
        fin = (rsp_last === 1'b1);
      end
      @(posedge clk);
    end
    if (!fin) begin
      miss("no reply");
      close_out();
    end
  endtask : apdu
  task automatic chk_rsp(input int nd, input logic [15:0] sw);
    int n;
    n = rsp_q.size();
    cmp_cnt(n, nd + 2, "reply length");
    if (n >= 2) cmp_sw({rsp_q[n-2], rsp_q[n-1]}, sw, "status word");
  endtask : chk_rsp
  task automatic err(input logic [7:0] b[$], input logic [15:0] sw);
    apdu(b);
    chk_rsp(0, sw);
  endtask : err
  task automatic rd(input logic [15:0] a, input logic [7:0] le, input logic [7:0] key);
    apdu({8'h00, ard_pkg::INS_READ, a[15:8], a[7:0], le});
    chk_rsp(le, ard_pkg::SW_OK);
    for (int i = 0; i < le && i + 2 < rsp_q.size(); i++)
      cmp_byte(rsp_q[i], 8'(a + 16'(i)) ^ key, "read data");
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] n, input logic h);
    logic [7:0] b[$];
    b = {8'h00, ard_pkg::INS_WRITE, a[15:8], a[7:0], n};
    for (int i = 0; i < n; i++) b.push_back(8'h60 + 8'(i));
    apdu(b);
    chk_rsp(0, ard_pkg::SW_OK);
    cmp_cnt(wd_q.size(), n, "write count");
    for (int i = 0; i < n && i < wd_q.size(); i++) begin
      cmp_byte(wd_q[i], 8'h60 + 8'(i), "write data");
      cmp_sw(wa_q[i], a + 16'(i), "write address");
      cmp_byte({7'h0, wh_q[i]}, {7'h0, h}, "write target");
    end
  endtask : wr
  task automatic vfy(input logic [7:0] p1, input logic [7:0] lc, input logic [7:0] flip,
                     input logic [15:0] sw);
    logic [7:0] b[$];
    b = {8'h00, ard_pkg::INS_VERIFY, p1, 8'h00, lc};
    for (int i = 0; i < lc; i++) b.push_back(PWD[127 - 8*i -: 8] ^ (i == 15 ? flip : 8'h00));
    apdu(b);
    chk_rsp(0, sw);
  endtask : vfy
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rw;
    rd(16'h12F0, 8'h03, MK);
    rd(16'h0000, 8'hFB, MK);
    lat <= 4'h5;
    tunnel_mode <= 1'b1;
    rd(16'hA501, 8'h01, HK);
    wr(16'h0AF0, 8'h02, 1'b1);
    tunnel_mode <= 1'b0;
    wr(16'h3301, 8'h01, 1'b0);
    $display("read and write done");
  endtask : t_rw
  task automatic t_err;
    err({8'h01, ard_pkg::INS_READ, 8'h00, 8'h00, 8'h01}, ard_pkg::SW_ERR_CLA);
    err({8'h80, ard_pkg::INS_WRITE, 8'h00, 8'h00, 8'h01, 8'h11}, ard_pkg::SW_ERR_CLA);
    vfy(8'h01, 8'h10, 8'h00, ard_pkg::SW_ERR_P12);
    vfy(8'h00, 8'h0F, 8'h00, ard_pkg::SW_ERR_LEN);
    vfy(8'h00, 8'h10, 8'h00, ard_pkg::SW_OK);
    vfy(8'h00, 8'h10, 8'h01, ard_pkg::SW_ERR_AUTH);
    err({8'h00, ard_pkg::INS_READ, 8'h00, 8'h00, 8'h00}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_READ, 8'h00, 8'h00, 8'hFC}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_WRITE, 8'h00, 8'h00, 8'h00}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_WRITE, 8'h00, 8'h00, 8'hF9, 8'h11}, ard_pkg::SW_ERR_LEN);
    err({8'h00, 8'h21, 8'h00, 8'h00, 8'h10}, ard_pkg::SW_ERR_INS);
    err({8'h00, ard_pkg::INS_VERIFY, 8'h00, 8'h01, 8'h10}, ard_pkg::SW_ERR_P12);
    err({8'h00, ard_pkg::INS_READ, 8'h00, 8'h00, 8'h01, 8'h55}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_READ, 8'h00}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_WRITE, 8'h00, 8'h00, 8'h02, 8'h11}, ard_pkg::SW_ERR_LEN);
    $display("error replies done");
  endtask : t_err
  task automatic t_enc;
    enc_mode <= 1'b1;
    lat <= 4'h2;
    rd(16'h0100, 8'hF0, MK);
    err({8'h00, ard_pkg::INS_READ, 8'h01, 8'h00, 8'h11}, ard_pkg::SW_ERR_LEN);
    err({8'h00, ard_pkg::INS_WRITE, 8'h00, 8'h00, 8'h11, 8'h22}, ard_pkg::SW_ERR_LEN);
    wr(16'h0200, 8'h10, 1'b0);
    enc_mode <= 1'b0;
    $display("encrypted lengths done");
  endtask : t_enc
  initial begin
    resetn = 1'b0;
    tunnel_mode = 1'b0;
    enc_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    rsp_ready = 1'b1;
    lat = 4'h1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_rw();
    t_err();
    t_enc();
    close_out();
  end
endmodule : ard_apdu_bench
`default_nettype wire
